/* File: hdl/dtio_pkg.sv */
// Constants, register map and types for the drive terminal I/O logic
package dtio_pkg;
  localparam int unsigned NUM_TERM = 5;
  localparam int unsigned FUNC_W = 5;
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned CUR_W = 8;
  // Register byte offsets
  localparam logic [7:0] ADDR_TERM_FUNC = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_UPDN_STEP = 8'h08;
  localparam logic [7:0] ADDR_DET_LEVEL = 8'h0c;
  localparam logic [7:0] ADDR_DET_WIDTH = 8'h10;
  localparam logic [7:0] ADDR_CUR_DET = 8'h14;
  localparam logic [7:0] ADDR_BRAKE = 8'h18;
  localparam logic [7:0] ADDR_UPPER = 8'h1c;
  localparam logic [7:0] ADDR_KEYPAD_FREQ = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_FREQ_CMD = 8'h28;
  // Configuration word layout
  localparam int unsigned CFG_POL_LSB = 0;
  localparam int unsigned CFG_SCAN_LSB = 8;
  localparam int unsigned CFG_SCAN_W = 8;
  localparam int unsigned CFG_KEEP_LSB = 16;
  localparam int unsigned CFG_RLY_LSB = 20;
  localparam int unsigned CFG_RLY_W = 4;
  localparam int unsigned CFG_NC_BIT = 24;
  localparam int unsigned CUR_PERIOD_LSB = 8;
  localparam int unsigned BRAKE_ENG_LSB = 16;
  // Status word layout
  localparam int unsigned ST_RELAY_BIT = 8;
  localparam int unsigned ST_PID_BIT = 9;
  localparam int unsigned ST_AUTO_BIT = 10;
  localparam int unsigned ST_UD_LSB = 12;
  // Reset values
  localparam logic [7:0] SCAN_RST = 8'h01;
  localparam logic [15:0] UPPER_RST = 16'hea60;
  // Terminal function codes
  localparam logic [4:0] FN_UP = 5'h08;
  localparam logic [4:0] FN_DOWN = 5'h09;
  localparam logic [4:0] FN_PID_OFF = 5'h10;
  localparam logic [4:0] FN_RESET = 5'h11;
  localparam logic [4:0] FN_AUTO = 5'h12;
  // Relay source codes
  localparam logic [3:0] RLY_RUN = 4'h0;
  localparam logic [3:0] RLY_FAULT = 4'h1;
  localparam logic [3:0] RLY_REACHED = 4'h2;
  localparam logic [3:0] RLY_WINDOW = 4'h3;
  localparam logic [3:0] RLY_ABOVE = 4'h4;
  localparam logic [3:0] RLY_BELOW = 4'h5;
  localparam logic [3:0] RLY_CURRENT = 4'hd;
  localparam logic [3:0] RLY_BRAKE = 4'he;
  // Stop-retention settings
  localparam logic [1:0] KEEP_HOLD_OFF = 2'h0;
  localparam logic [1:0] KEEP_ZERO = 2'h1;
  localparam logic [1:0] KEEP_HOLD_ON = 2'h2;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_S = 2;
  localparam int unsigned MS_PER_S = 1000;
  localparam logic [11:0] HOLD_MS = 12'(HOLD_S * MS_PER_S);
  localparam logic [14:0] CUR_UNIT_MS = 15'h0064;
  localparam logic [15:0] FREQ_TOL = 16'h0001;
  localparam logic [15:0] RAMP_LSB = 16'h0001;
  typedef enum logic [2:0] {
    UD_IDLE = 3'b001,
    UD_HOLD = 3'b010,
    UD_RAMP = 3'b100
  } dtio_updn_st_t;
endpackage : dtio_pkg

/* File: hdl/dtio_top.sv */
// Terminal conditioning, terminal functions, up/down command and relay source logic
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Regulator disabled while a regulator-disable terminal is active, enabled again after.
// - Reset terminal activation clears a latched, manually resettable fault.
// - An auto-run terminal enables the automatic sequencer.
// - Step size 0.00-5.00 Hz; a press under 2 s changes command one step.
// - Up/down held beyond 2 s ramps the command while held.
// - Stop retention: 0 hold and disable, 1 zero, 2 hold and keep enabled.
// - Retention 0 or 2: on stop, output frequency copied to keypad frequency.
// - Retention 1: run starts from 0 Hz, stop returns to 0 Hz.
// - Inputs debounced over 1-200 ms scan; shorter states are ignored.
// - Five polarity bits, bit 0 terminal one; 1 means normally closed.
// - Relay source 0: on while run command active.
// - Relay source 1: on while drive faulted.
// - Relay source 2: on in run when output reaches setting minus width.
// - Relay source 3: on when setting and output both inside level plus/minus width.
// - Relay source 4: on while output above detection level.
// - Relay source 5: on while output below detection level.
// - Relay source 13: on when output current stays above current detection level for the detection time, in 100 ms units.
// - Relay source 14: on when accelerating output reaches brake release level.
// - Relay source 14: off when decelerating output reaches brake engage level.
// - Contact type bit inverts relay sense: 0 normally open, 1 normally closed.
// - Up stops at upper frequency limit, down stops at zero.
module dtio_top #(
  parameter int unsigned TICK_CYCLES = dtio_pkg::TICK_CYCLES // Clock cycles per 1 ms tick
) (
  input wire logic clock, // 100 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic input_terminal_1, // Multifunction terminal 1 pin
  input wire logic input_terminal_2, // Multifunction terminal 2 pin
  input wire logic input_terminal_3, // Multifunction terminal 3 pin
  input wire logic input_terminal_4, // Multifunction terminal 4 pin
  input wire logic input_terminal_5, // Multifunction terminal 5 pin
  input wire logic run_active, // Drive run command
  input wire logic fault_active, // Drive fault latched
  input wire logic fault_resettable, // Present fault may be reset manually
  input wire logic [15:0] out_freq, // Output frequency, 0.01 Hz
  input wire logic [15:0] set_freq, // Setting frequency, 0.01 Hz
  input wire logic [7:0] out_current, // Output current, 0.1 A
  input wire logic accelerating, // Drive accelerating
  input wire logic decelerating, // Drive decelerating
  output logic relay_output, // Relay coil drive
  output logic pid_disable, // Closed-loop regulator disabled
  output logic fault_reset, // One-cycle fault reset request
  output logic auto_run_en, // Automatic sequencer enabled
  output logic [15:0] freq_cmd, // Up/down frequency command
  output logic [15:0] keypad_freq, // Stored keypad frequency
  output logic ramp_up, // Continuous ramp up active
  output logic ramp_down // Continuous ramp down active
);
  localparam int unsigned N = dtio_pkg::NUM_TERM;
  localparam int unsigned FW = dtio_pkg::FUNC_W;

  logic [16:0] tick_cnt_r;
  logic tick;
  logic [N*FW-1:0] term_func_r;
  logic [N-1:0] pol_r;
  logic [7:0] scan_r;
  logic [1:0] keep_r;
  logic [3:0] rly_func_r;
  logic rly_nc_r;
  logic [15:0] step_r, det_level_r, det_width_r, upper_r, keypad_r, freq_cmd_r;
  logic [15:0] brk_rel_r, brk_eng_r;
  logic [7:0] cur_level_r, cur_period_r;
  logic [31:0] rdata_r;
  logic [N-1:0] pin_raw, term_state;
  logic [N-1:0] up_hit, dn_hit, pid_hit, rst_hit, auto_hit;
  logic [7:0] deb_cnt [N];
  logic [7:0] scan_eff;
  logic up_act, dn_act, key, dir_up;
  logic pid_r, auto_r, rst_d_r, fault_reset_r;
  logic run_d_r, run_fall;
  logic updn_en, ud_step, ud_ramp_tick;
  dtio_pkg::dtio_updn_st_t ud_st_r;
  logic [11:0] hold_cnt_r;
  logic ramp_up_r, ramp_dn_r;
  logic [14:0] cur_cnt_r, cur_target;
  logic cur_on_r, brake_r, relay_sel, relay_r;
  logic [15:0] set_lo, lvl_lo;
  logic [16:0] set_hi, lvl_hi;

  // Time base: one tick per millisecond
  always_ff @(posedge clock) begin
    if (sys_rst || tick) tick_cnt_r <= 17'h00000;
    else tick_cnt_r <= tick_cnt_r + 17'h00001;
  end
  assign tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));

  // Register writes; the stop-time copy wins over a software write to keypad frequency
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      term_func_r <= '0;
      pol_r <= '0;
      scan_r <= dtio_pkg::SCAN_RST;
      keep_r <= dtio_pkg::KEEP_HOLD_OFF;
      rly_func_r <= dtio_pkg::RLY_RUN;
      rly_nc_r <= 1'b0;
      step_r <= 16'h0000;
      det_level_r <= 16'h0000;
      det_width_r <= 16'h0000;
      cur_level_r <= 8'h00;
      cur_period_r <= 8'h00;
      brk_rel_r <= 16'h0000;
      brk_eng_r <= 16'h0000;
      upper_r <= dtio_pkg::UPPER_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        dtio_pkg::ADDR_TERM_FUNC: term_func_r <= reg_wdata[N*FW-1:0];
        dtio_pkg::ADDR_CONFIG: begin
          pol_r <= reg_wdata[dtio_pkg::CFG_POL_LSB +: N];
          scan_r <= reg_wdata[dtio_pkg::CFG_SCAN_LSB +: dtio_pkg::CFG_SCAN_W];
          keep_r <= reg_wdata[dtio_pkg::CFG_KEEP_LSB +: 2];
          rly_func_r <= reg_wdata[dtio_pkg::CFG_RLY_LSB +: dtio_pkg::CFG_RLY_W];
          rly_nc_r <= reg_wdata[dtio_pkg::CFG_NC_BIT];
        end
        dtio_pkg::ADDR_UPDN_STEP: step_r <= reg_wdata[15:0];
        dtio_pkg::ADDR_DET_LEVEL: det_level_r <= reg_wdata[15:0];
        dtio_pkg::ADDR_DET_WIDTH: det_width_r <= reg_wdata[15:0];
        dtio_pkg::ADDR_CUR_DET: begin
          cur_level_r <= reg_wdata[7:0];
          cur_period_r <= reg_wdata[dtio_pkg::CUR_PERIOD_LSB +: 8];
        end
        dtio_pkg::ADDR_BRAKE: begin
          brk_rel_r <= reg_wdata[15:0];
          brk_eng_r <= reg_wdata[dtio_pkg::BRAKE_ENG_LSB +: 16];
        end
        dtio_pkg::ADDR_UPPER: upper_r <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) keypad_r <= 16'h0000;
    else if (run_fall && keep_r != dtio_pkg::KEEP_ZERO) keypad_r <= out_freq;
    else if (reg_wr && reg_addr == dtio_pkg::ADDR_KEYPAD_FREQ) keypad_r <= reg_wdata[15:0];
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (sys_rst || !reg_rd) rdata_r <= 32'h00000000;
    else begin
      case (reg_addr)
        dtio_pkg::ADDR_TERM_FUNC: rdata_r <= 32'(term_func_r);
        dtio_pkg::ADDR_CONFIG: rdata_r <= 32'(pol_r) | (32'(scan_r) << dtio_pkg::CFG_SCAN_LSB)
                                        | (32'(keep_r) << dtio_pkg::CFG_KEEP_LSB)
                                        | (32'(rly_func_r) << dtio_pkg::CFG_RLY_LSB)
                                        | (32'(rly_nc_r) << dtio_pkg::CFG_NC_BIT);
        dtio_pkg::ADDR_UPDN_STEP: rdata_r <= 32'(step_r);
        dtio_pkg::ADDR_DET_LEVEL: rdata_r <= 32'(det_level_r);
        dtio_pkg::ADDR_DET_WIDTH: rdata_r <= 32'(det_width_r);
        dtio_pkg::ADDR_CUR_DET: rdata_r <= 32'(cur_level_r) | (32'(cur_period_r) << dtio_pkg::CUR_PERIOD_LSB);
        dtio_pkg::ADDR_BRAKE: rdata_r <= 32'(brk_rel_r) | (32'(brk_eng_r) << dtio_pkg::BRAKE_ENG_LSB);
        dtio_pkg::ADDR_UPPER: rdata_r <= 32'(upper_r);
        dtio_pkg::ADDR_KEYPAD_FREQ: rdata_r <= 32'(keypad_r);
        dtio_pkg::ADDR_STATUS: rdata_r <= 32'(term_state) | (32'(relay_r) << dtio_pkg::ST_RELAY_BIT)
                                        | (32'(pid_r) << dtio_pkg::ST_PID_BIT)
                                        | (32'(auto_r) << dtio_pkg::ST_AUTO_BIT)
                                        | (32'(ud_st_r) << dtio_pkg::ST_UD_LSB);
        dtio_pkg::ADDR_FREQ_CMD: rdata_r <= 32'(freq_cmd_r);
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  // Input conditioning per terminal
  assign pin_raw = {input_terminal_5, input_terminal_4, input_terminal_3, input_terminal_2, input_terminal_1};
  // A zero scan setting is out of range; treat it as the shortest period
  assign scan_eff = (scan_r == 8'h00) ? 8'h01 : scan_r;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_term
      logic s1_r, s2_r, s3_r, state_r;
      logic lvl;
      logic [7:0] cnt_r;
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      assign lvl = s3_r ^ pol_r[gi];
      // Disagreement must last a whole scan period, else it is noise
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          state_r <= 1'b0;
          cnt_r <= 8'h00;
        end else if (s2_r == s3_r && lvl != state_r) begin
          if (tick) begin
            if (cnt_r + 8'h01 >= scan_eff) begin
              state_r <= lvl;
              cnt_r <= 8'h00;
            end else cnt_r <= cnt_r + 8'h01;
          end
        end else cnt_r <= 8'h00;
      end
      assign term_state[gi] = state_r;
      assign deb_cnt[gi] = cnt_r;
      assign up_hit[gi] = state_r && term_func_r[gi*FW +: FW] == dtio_pkg::FN_UP;
      assign dn_hit[gi] = state_r && term_func_r[gi*FW +: FW] == dtio_pkg::FN_DOWN;
      assign pid_hit[gi] = state_r && term_func_r[gi*FW +: FW] == dtio_pkg::FN_PID_OFF;
      assign rst_hit[gi] = state_r && term_func_r[gi*FW +: FW] == dtio_pkg::FN_RESET;
      // Assignment alone enables the sequencer, independent of the terminal level
      assign auto_hit[gi] = term_func_r[gi*FW +: FW] == dtio_pkg::FN_AUTO;
    end
  endgenerate

  assign up_act = |up_hit;
  assign dn_act = |dn_hit;
  // Up and down together cancel
  assign key = up_act ^ dn_act;
  assign dir_up = up_act;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pid_r <= 1'b0;
      auto_r <= 1'b0;
      rst_d_r <= 1'b0;
      fault_reset_r <= 1'b0;
      run_d_r <= 1'b0;
    end else begin
      pid_r <= |pid_hit;
      auto_r <= |auto_hit;
      rst_d_r <= |rst_hit;
      fault_reset_r <= (|rst_hit) && !rst_d_r && fault_active && fault_resettable;
      run_d_r <= run_active;
    end
  end
  assign run_fall = run_d_r && !run_active;

  // Up/down: a press steps once; holding past the hold time ramps
  assign updn_en = run_active || keep_r == dtio_pkg::KEEP_HOLD_ON;
  assign ud_step = ud_st_r == dtio_pkg::UD_IDLE && key && updn_en;
  assign ud_ramp_tick = ud_st_r == dtio_pkg::UD_RAMP && key && updn_en && tick;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ud_st_r <= dtio_pkg::UD_IDLE;
      hold_cnt_r <= 12'h000;
    end else begin
      case (ud_st_r)
        dtio_pkg::UD_IDLE: begin
          hold_cnt_r <= 12'h000;
          if (ud_step) ud_st_r <= dtio_pkg::UD_HOLD;
        end
        dtio_pkg::UD_HOLD: begin
          if (!key) ud_st_r <= dtio_pkg::UD_IDLE;
          else if (tick) begin
            if (hold_cnt_r >= dtio_pkg::HOLD_MS - 12'h001) ud_st_r <= dtio_pkg::UD_RAMP;
            else hold_cnt_r <= hold_cnt_r + 12'h001;
          end
        end
        dtio_pkg::UD_RAMP: if (!key) ud_st_r <= dtio_pkg::UD_IDLE;
        default: ud_st_r <= dtio_pkg::UD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ramp_up_r <= 1'b0;
      ramp_dn_r <= 1'b0;
    end else begin
      ramp_up_r <= ud_st_r == dtio_pkg::UD_RAMP && key && dir_up && updn_en;
      ramp_dn_r <= ud_st_r == dtio_pkg::UD_RAMP && key && !dir_up && updn_en;
    end
  end

  function automatic logic [15:0] step_f(input logic [15:0] f, input logic [15:0] d,
                                         input logic up, input logic [15:0] lim);
    logic [16:0] s;
    s = {1'b0, f} + {1'b0, d};
    if (up) step_f = (s > {1'b0, lim}) ? lim : s[15:0];
    else step_f = (d > f) ? 16'h0000 : f - d;
  endfunction : step_f

  // Stop handling has priority over up/down changes in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) freq_cmd_r <= 16'h0000;
    else if (run_fall && keep_r == dtio_pkg::KEEP_ZERO) freq_cmd_r <= 16'h0000;
    else if (run_fall) freq_cmd_r <= out_freq;
    else if (ud_step) freq_cmd_r <= step_f(freq_cmd_r, step_r, dir_up, upper_r);
    else if (ud_ramp_tick) freq_cmd_r <= step_f(freq_cmd_r, dtio_pkg::RAMP_LSB, dir_up, upper_r);
  end

  // Relay sources
  assign set_lo = (set_freq > det_width_r) ? set_freq - det_width_r : 16'h0000;
  assign set_hi = {1'b0, set_freq} + {1'b0, dtio_pkg::FREQ_TOL};
  assign lvl_lo = (det_level_r > det_width_r) ? det_level_r - det_width_r : 16'h0000;
  assign lvl_hi = {1'b0, det_level_r} + {1'b0, det_width_r};
  assign cur_target = 15'(cur_period_r * dtio_pkg::CUR_UNIT_MS);

  always_ff @(posedge clock) begin
    if (sys_rst || out_current <= cur_level_r) begin
      cur_cnt_r <= 15'h0000;
      cur_on_r <= 1'b0;
    end else if (tick && !cur_on_r) begin
      if (cur_cnt_r + 15'h0001 >= cur_target) cur_on_r <= 1'b1;
      else cur_cnt_r <= cur_cnt_r + 15'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) brake_r <= 1'b0;
    else if (accelerating && out_freq >= brk_rel_r) brake_r <= 1'b1;
    else if (decelerating && out_freq <= brk_eng_r) brake_r <= 1'b0;
  end

  always_comb begin
    relay_sel = 1'b0;
    case (rly_func_r)
      dtio_pkg::RLY_RUN: relay_sel = run_active;
      dtio_pkg::RLY_FAULT: relay_sel = fault_active;
      dtio_pkg::RLY_REACHED: relay_sel = run_active && ({1'b0, out_freq} + {1'b0, dtio_pkg::FREQ_TOL} >= {1'b0, set_lo})
                                         && {1'b0, out_freq} <= set_hi;
      dtio_pkg::RLY_WINDOW: relay_sel = set_freq >= lvl_lo && {1'b0, set_freq} <= lvl_hi
                                        && out_freq >= lvl_lo && {1'b0, out_freq} <= lvl_hi;
      dtio_pkg::RLY_ABOVE: relay_sel = out_freq > det_level_r;
      dtio_pkg::RLY_BELOW: relay_sel = out_freq < det_level_r;
      dtio_pkg::RLY_CURRENT: relay_sel = cur_on_r;
      dtio_pkg::RLY_BRAKE: relay_sel = brake_r;
      default: relay_sel = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) relay_r <= 1'b0;
    else relay_r <= relay_sel ^ rly_nc_r;
  end

  assign reg_rdata = rdata_r;
  assign relay_output = relay_r;
  assign pid_disable = pid_r;
  assign fault_reset = fault_reset_r;
  assign auto_run_en = auto_r;
  assign freq_cmd = freq_cmd_r;
  assign keypad_freq = keypad_r;
  assign ramp_up = ramp_up_r;
  assign ramp_down = ramp_dn_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_press;
    ud_step && dir_up && !run_fall;
  endsequence
  sequence s_ramp_entry;
    ud_st_r == dtio_pkg::UD_HOLD && key && tick && hold_cnt_r == dtio_pkg::HOLD_MS - 12'h001;
  endsequence

  AST_PID_FOLLOWS: assert property ((|pid_hit) != pid_r |=> pid_disable == $past(|pid_hit))
    else $error("regulator disable does not follow terminal");
  AST_FAULT_RESET: assert property ($rose(|rst_hit) && fault_active && fault_resettable |=> fault_reset ##1 !fault_reset)
    else $error("fault reset pulse wrong");
  AST_AUTO_RUN: assert property ((|auto_hit) |=> auto_run_en)
    else $error("sequencer not enabled");
  AST_STEP_UP: assert property (s_press ##0 ({1'b0, freq_cmd_r} + {1'b0, step_r} <= {1'b0, upper_r})
                                |=> freq_cmd == $past(freq_cmd_r) + $past(step_r))
    else $error("up step not applied once");
  AST_RAMP_ENTRY: assert property (s_ramp_entry ##1 key[*2] |-> ud_st_r == dtio_pkg::UD_RAMP ##0 (ramp_up || ramp_down || !updn_en))
    else $error("ramp not entered after hold time");
  AST_UPPER_CLAMP: assert property (ud_ramp_tick && dir_up && !run_fall && freq_cmd_r == upper_r |=> freq_cmd == $past(upper_r))
    else $error("up ramp passed upper limit");
  AST_STOP_ZERO: assert property (run_fall && keep_r == dtio_pkg::KEEP_ZERO |=> freq_cmd == 16'h0000)
    else $error("command not zeroed on stop");
  AST_STOP_STORE: assert property (run_fall && keep_r != dtio_pkg::KEEP_ZERO |=> keypad_freq == $past(out_freq))
    else $error("output frequency not stored on stop");
  AST_DEBOUNCE: assert property ($changed(term_state[0]) |-> $past(tick) && $past(deb_cnt[0]) + 8'h01 >= $past(scan_eff))
    else $error("terminal changed before scan period");
  AST_RELAY_ABOVE: assert property (rly_func_r == dtio_pkg::RLY_ABOVE && $stable(rly_func_r) && $stable(rly_nc_r)
                                    |=> relay_output == ($past(out_freq > det_level_r) ^ $past(rly_nc_r)))
    else $error("relay above-level source wrong");
  AST_RELAY_FAULT: assert property (rly_func_r == dtio_pkg::RLY_FAULT && fault_active && !rly_nc_r ##1 !rly_nc_r |-> relay_output)
    else $error("relay not on with fault");
  AST_CURRENT_WAIT: assert property ($rose(cur_on_r) |-> $past(cur_cnt_r) + 15'h0001 >= $past(cur_target) && $past(out_current > cur_level_r))
    else $error("current relay asserted early");
endmodule : dtio_top
`default_nettype wire

/* File: sim/dtio_switches.sv */
// External contact switches on the terminals and the load hung on the relay
`timescale 1ns/10ps
`default_nettype none
module dtio_switches (
  input wire logic clock, // Bench clock
  input wire logic [4:0] closed, // Contacts the operator holds closed
  input wire logic relay_output, // Relay coil drive
  output logic [4:0] pins, // Terminal levels seen by the block
  output logic load_on // External load energised
);
  // Contacts change only at edges; polarity is always set before contacts move
  always_ff @(posedge clock) begin
    pins <= closed;
  end
  assign load_on = relay_output;
endmodule : dtio_switches
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the drive terminal I/O logic
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, run_active = 1'b0, fault_active = 1'b0, fault_resettable = 1'b0;
  logic [15:0] out_freq = 16'h0, set_freq = 16'h0, freq_cmd, keypad_freq;
  logic [7:0] out_current = 8'h00;
  logic accelerating = 1'b0, decelerating = 1'b0, relay_output, pid_disable, fault_reset, auto_run_en;
  logic ramp_up, ramp_down, load_on;
  logic [4:0] closed = 5'h00, pins;
  int miscompares = 0, tests_run = 0, src, nc, lvl, outf, exp_v, step;
  int srcs[4] = '{0, 1, 4, 5};
  always #5 clock = ~clock;
  dtio_switches sw (.clock, .closed, .relay_output, .pins, .load_on);
  dtio_top #(.TICK_CYCLES(10)) dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(rdata), .input_terminal_1(pins[0]), .input_terminal_2(pins[1]), .input_terminal_3(pins[2]),
    .input_terminal_4(pins[3]), .input_terminal_5(pins[4]), .run_active, .fault_active, .fault_resettable,
    .out_freq, .set_freq, .out_current, .accelerating, .decelerating, .relay_output, .pid_disable, .fault_reset,
    .auto_run_en, .freq_cmd, .keypad_freq, .ramp_up, .ramp_down);
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask : rd
  task automatic press(input logic [4:0] k, input int n);
    closed <= k;
    repeat (n) @(posedge clock);
    closed <= 5'h00;
    repeat (60) @(posedge clock);
  endtask : press
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    src = $urandom(32'h1c64);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    wr(dtio_pkg::ADDR_KEYPAD_FREQ, 32'h0000_1234);
    rd(dtio_pkg::ADDR_KEYPAD_FREQ, d); chk("keypad_reg", 32'h1234, d);
    rd(8'h80, d); chk("unmapped", 32'h0, d);
    for (int i = 0; i < 8; i++) begin
      src = srcs[i % 4]; nc = i / 4;
      lvl = $urandom_range(60000); outf = $urandom_range(60000);
      wr(dtio_pkg::ADDR_DET_LEVEL, 32'(lvl));
      wr(dtio_pkg::ADDR_CONFIG, 32'((nc << 24) | (src << 20) | 32'h300));
      run_active <= 1'($urandom); fault_active <= 1'($urandom); out_freq <= 16'(outf);
      repeat (3) @(posedge clock);
      exp_v = (src == 0) ? run_active : (src == 1) ? fault_active : (src == 4) ? (outf > lvl) : (outf < lvl);
      chk("relay", 32'(exp_v ^ nc), relay_output);
    end
    $display("relay sources done");
    wr(dtio_pkg::ADDR_TERM_FUNC, 32'({dtio_pkg::FN_UP, dtio_pkg::FN_PID_OFF}));
    wr(dtio_pkg::ADDR_CONFIG, 32'h0000_0301);
    repeat (60) @(posedge clock);
    chk("pid_nc_idle", 32'h1, pid_disable);
    press(5'h01, 5); chk("pid_glitch", 32'h1, pid_disable);
    closed <= 5'h01; repeat (60) @(posedge clock);
    chk("pid_enabled", 32'h0, pid_disable);
    closed <= 5'h00; out_freq <= 16'h0; run_active <= 1'b1;
    repeat (60) @(posedge clock);
    run_active <= 1'b0; repeat (3) @(posedge clock); run_active <= 1'b1;
    $display("terminal conditioning done");
    step = $urandom_range(500, 1); exp_v = 0;
    wr(dtio_pkg::ADDR_UPDN_STEP, 32'(step));
    for (int k = 0; k < 3; k++) begin
      press(5'h02, 60); exp_v += step;
      chk("freq_cmd_step", 32'(exp_v), freq_cmd);
    end
    closed <= 5'h02; repeat (20300) @(posedge clock);
    chk("ramp_up", 32'h1, ramp_up);
    press(5'h00, 1); chk("ramp_stop", 32'h0, ramp_up);
    wr(dtio_pkg::ADDR_CONFIG, 32'h0001_0301);
    run_active <= 1'b0; repeat (3) @(posedge clock);
    chk("stop_zero", 32'h0, freq_cmd);
    wr(dtio_pkg::ADDR_CONFIG, 32'h0002_0301);
    outf = $urandom_range(50000); out_freq <= 16'(outf); run_active <= 1'b1;
    repeat (3) @(posedge clock);
    run_active <= 1'b0; repeat (3) @(posedge clock);
    chk("keypad_copy", 32'(outf), keypad_freq);
    press(5'h02, 60); chk("updn_stopped", 32'(outf + step), freq_cmd);
    $display("up/down and stop retention done");
    wr(dtio_pkg::ADDR_TERM_FUNC, 32'({dtio_pkg::FN_AUTO, dtio_pkg::FN_RESET, dtio_pkg::FN_DOWN, dtio_pkg::FN_UP,
                                      dtio_pkg::FN_PID_OFF}));
    repeat (3) @(posedge clock);
    chk("auto_run", 32'h1, auto_run_en);
    press(5'h04, 60); chk("freq_cmd_down", 32'(outf), freq_cmd);
    closed <= 5'h04; repeat (20300) @(posedge clock);
    chk("ramp_down", 32'h1, ramp_down);
    press(5'h00, 1); chk("ramp_down_stop", 32'h0, ramp_down);
    // A one-cycle pulse is counted over the whole press so it cannot slip between looks
    fault_active <= 1'b1; fault_resettable <= 1'b1; closed <= 5'h08; d = 32'h0;
    repeat (60) begin
      @(posedge clock);
      d += 32'(fault_reset);
    end
    chk("fault_reset_pulses", 32'h1, d);
    closed <= 5'h00; fault_active <= 1'b0; repeat (60) @(posedge clock);
    $display("terminal functions done");
    wr(dtio_pkg::ADDR_DET_WIDTH, 32'd500);
    wr(dtio_pkg::ADDR_CONFIG, 32'h0022_0301);
    set_freq <= 16'd3000; out_freq <= 16'd2600; run_active <= 1'b1; repeat (3) @(posedge clock);
    chk("relay_reached", 32'h1, relay_output);
    out_freq <= 16'd2400; repeat (3) @(posedge clock);
    chk("relay_not_reached", 32'h0, relay_output);
    wr(dtio_pkg::ADDR_DET_LEVEL, 32'd3000);
    wr(dtio_pkg::ADDR_CONFIG, 32'h0032_0301);
    out_freq <= 16'd2600; repeat (3) @(posedge clock);
    chk("relay_window_in", 32'h1, relay_output);
    out_freq <= 16'd3600; repeat (3) @(posedge clock);
    chk("relay_window_out", 32'h0, relay_output);
    wr(dtio_pkg::ADDR_CUR_DET, 32'h0000_010a);
    wr(dtio_pkg::ADDR_CONFIG, 32'h00d2_0301);
    out_current <= 8'h0b; repeat (500) @(posedge clock);
    chk("relay_current_wait", 32'h0, relay_output);
    repeat (600) @(posedge clock);
    chk("relay_current", 32'h1, relay_output);
    chk("load_on", 32'h1, load_on);
    wr(dtio_pkg::ADDR_BRAKE, 32'h0080_0100);
    wr(dtio_pkg::ADDR_CONFIG, 32'h00e2_0301);
    accelerating <= 1'b1; out_freq <= 16'h0100; repeat (3) @(posedge clock);
    chk("brake_release", 32'h1, relay_output);
    accelerating <= 1'b0; decelerating <= 1'b1; out_freq <= 16'h00c0; repeat (3) @(posedge clock);
    chk("brake_held", 32'h1, relay_output);
    out_freq <= 16'h0080; repeat (3) @(posedge clock);
    chk("brake_engage", 32'h0, relay_output);
    decelerating <= 1'b0;
    $display("relay comparisons done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
